// ==== rtl/cvr_ctrl.sv ====
// Comparator voltage reference control: one 8-bit control register on APB,
// driving the ladder power, source mux, range, tap code and pin routing.
// Assumes a single 125 MHz clock; port direction bit comes from a pin domain.
//
// How it works
// - bit 7 powers the reference ladder on when set
// - bit 6 routes the level to the shared pin, gated by the direction bit
// - bit 5 picks low range (steps of 1/24) or high (1/32 from 1/4)
// - bit 4 picks external reference pins or device supply as source
// - bits 3..0 hold the tap code, sixteen levels
// - level is tap/24 of source, or source/4 plus tap/32
// - all eight bits read and write, zero after power-on
// - reset clears the register: powered down, disconnected, high range
// - register keeps its contents across sleep and wake
// - pin connects when direction bit and pin enable are both set
// - works regardless of comparator configuration
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module cvr_ctrl (
    input wire logic i_clk_sys, // System clock 125 MHz
    input wire logic i_rst, // Async reset, active high
    input wire logic i_psel, // APB select
    input wire logic i_penable, // APB enable
    input wire logic i_pwrite, // APB write
    input wire logic [11:0] i_paddr, // APB byte address
    input wire logic [31:0] i_pwdata, // APB write data
    input wire logic [3:0] i_pstrb, // APB byte strobes
    output logic [31:0] o_prdata, // APB read data
    output logic o_pready, // APB ready
    output logic o_pslverr, // APB error
    input wire logic i_sleep, // Device asleep, no effect on contents
    input wire logic i_port_a_direction, // Direction bit of shared pin
    output logic o_ladder_power_enable, // Ladder powered
    output logic o_source_select, // External reference source
    output logic o_range_select, // Low range selected
    output logic [3:0] o_tap_code, // Tap code
    output logic o_pin_output_enable, // Pin route bit
    output logic o_pin_connect, // Level switched onto pin
    output cvr_pkg::cvr_level_t o_reference_level // Level fraction of source
);
    import cvr_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic dir_meta;
        logic dir_sync;
        logic pin_connect;
    } cvr_state_t;

    cvr_state_t state;
    cvr_state_t next_state;
    cvr_level_t level;

    logic access;
    logic wr;
    logic rd;

    // Valid APB offsets
    function automatic logic addr_ok(input logic [11:0] a);
        if (a == `CVR_CTRL_OFFSET) begin
            addr_ok = 1'b1;
        end else if (a == `CVR_STATUS_OFFSET) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    endfunction : addr_ok

    // Zero-wait APB strobes
    assign access = i_psel & i_penable;
    assign wr = access & i_pwrite;
    assign rd = access & ~i_pwrite;

    // Next state: direction sync, register writes, pin routing
    always_comb begin
        next_state = state;
        next_state.dir_meta = i_port_a_direction;
        next_state.dir_sync = state.dir_meta;
        // Sleep is ignored so contents persist; no comparator inputs at all
        if (wr && i_paddr == `CVR_CTRL_OFFSET && i_pstrb[0]) begin
            next_state.ctrl = i_pwdata[7:0];
        end
        // Level reaches the pin only with route bit and synchronised direction bit set
        next_state.pin_connect = state.ctrl[`CVR_BIT_PIN_OE] & state.dir_sync;
        if (i_sleep) begin
            next_state.ctrl = next_state.ctrl;
        end
    end

    // Registered state, all cleared on reset
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state <= '{ctrl: `CVR_CTRL_RESET, default: '0};
        end else begin
            state <= next_state;
        end
    end

    // Level arithmetic
    cvr_level_calc u_calc (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_range_low(state.ctrl[`CVR_BIT_RANGE]),
        .i_tap_code(state.ctrl[`CVR_TAP_MSB:`CVR_TAP_LSB]),
        .o_level(level)
    );

    // Bus answers
    assign o_pready = 1'b1;
    assign o_prdata = rd ? ((i_paddr == `CVR_CTRL_OFFSET) ? {24'h000000, state.ctrl}
        : (i_paddr == `CVR_STATUS_OFFSET) ? {16'h0000, level.num, level.den} : 32'h0) : 32'h0;
    assign o_pslverr = access & ~addr_ok(i_paddr);

    // Analog controls from the register; pin switch and level from their own flops
    assign o_ladder_power_enable = state.ctrl[`CVR_BIT_POWER];
    assign o_pin_output_enable = state.ctrl[`CVR_BIT_PIN_OE];
    assign o_range_select = state.ctrl[`CVR_BIT_RANGE];
    assign o_source_select = state.ctrl[`CVR_BIT_SOURCE];
    assign o_tap_code = state.ctrl[`CVR_TAP_MSB:`CVR_TAP_LSB];
    assign o_pin_connect = state.pin_connect;
    assign o_reference_level = level;
endmodule : cvr_ctrl

`default_nettype wire

// ==== rtl/cvr_level_calc.sv ====
// Converts range and tap code to a level fraction of the ladder source.
// Pure registered arithmetic on the system clock.
`timescale 1ns/1ps
`default_nettype none

module cvr_level_calc (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst, // Async reset, active high
    input wire logic i_range_low, // Low range selected
    input wire logic [3:0] i_tap_code, // Tap code
    output cvr_pkg::cvr_level_t o_level // Level fraction
);
    import cvr_pkg::*;

    typedef struct packed {
        cvr_level_t level;
    } cvr_calc_state_t;

    cvr_calc_state_t state;
    cvr_calc_state_t next_state;

    // Fraction of source for the chosen range
    function automatic cvr_level_t level_of(input logic low, input logic [3:0] tap);
        cvr_level_t l;
        if (low) begin
            l.num = {4'h0, tap};
            l.den = `CVR_LOW_DENOM;
        end else begin
            l.num = `CVR_HIGH_BASE_NUM + {4'h0, tap};
            l.den = `CVR_HIGH_DENOM;
        end
        return l;
    endfunction : level_of

    // Next value
    always_comb begin
        next_state = state;
        next_state.level = level_of(i_range_low, i_tap_code);
    end

    // Registered state
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state <= '{level: '{num: 8'h08, den: 8'h20}};
        end else begin
            state <= next_state;
        end
    end

    assign o_level = state.level;
endmodule : cvr_level_calc

`default_nettype wire

// ==== rtl/cvr_params.svh ====
// Register offsets, field positions, reset values and level constants for the
// comparator reference control block. Included by the package; the RTL sees its macros through the package file.
`ifndef CVR_PARAMS_SVH
`define CVR_PARAMS_SVH

`define CVR_CTRL_OFFSET 12'h000
`define CVR_STATUS_OFFSET 12'h004
`define CVR_CTRL_RESET 8'h00
`define CVR_BIT_POWER 7
`define CVR_BIT_PIN_OE 6
`define CVR_BIT_RANGE 5
`define CVR_BIT_SOURCE 4
`define CVR_TAP_MSB 3
`define CVR_TAP_LSB 0
`define CVR_LOW_DENOM 8'd24
`define CVR_HIGH_DENOM 8'd32
`define CVR_HIGH_BASE_NUM 8'd8

`endif

// ==== rtl/cvr_pkg.sv ====
// Types shared by the comparator reference control logic.
// Assumes cvr_params.svh is on the include path.
`include "cvr_params.svh"

package cvr_pkg;
    // Range of the ladder
    typedef enum logic [1:0] {
        CVR_RANGE_HIGH = 2'b01,
        CVR_RANGE_LOW = 2'b10
    } cvr_range_t;

    // Level as numerator over denominator of the ladder source
    typedef struct packed {
        logic [7:0] num;
        logic [7:0] den;
    } cvr_level_t;
endpackage : cvr_pkg

// ==== tb/cvr_ctrl_props.sv ====
// Checker for the reference control block ports.
// Assumes one clock and the active-high async reset.
`timescale 1ns/1ps
`default_nettype none
module cvr_ctrl_props (
    input wire logic i_clk_sys, // Clock
    input wire logic i_rst, // Reset
    input wire logic i_psel, // Select
    input wire logic i_penable, // Enable
    input wire logic i_pwrite, // Write
    input wire logic [11:0] i_paddr, // Address
    input wire logic [31:0] i_pwdata, // Data
    input wire logic [3:0] i_pstrb, // Strobes
    input wire logic i_port_a_direction, // Pin direction
    input wire logic [31:0] o_prdata, // Read data
    input wire logic o_pslverr, // Error
    input wire logic o_ladder_power_enable, // Power
    input wire logic o_source_select, // Source
    input wire logic o_range_select, // Range
    input wire logic [3:0] o_tap_code, // Tap
    input wire logic o_pin_output_enable, // Route
    input wire logic o_pin_connect, // Switch
    input wire cvr_pkg::cvr_level_t o_reference_level // Level
);
    import cvr_pkg::*;
    logic [7:0] ctrl;
    // Control byte as seen on the outputs
    assign ctrl = {o_ladder_power_enable, o_pin_output_enable, o_range_select,
        o_source_select, o_tap_code};
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence s_acc; i_psel && i_penable; endsequence
    sequence s_wr; s_acc ##0 (i_pwrite && i_paddr == 12'h000 && i_pstrb[0]); endsequence
    a_write_fields: assert property (s_wr |=> ctrl == 8'($past(i_pwdata)))
        else $error("control bits differ from write");
    a_hold_ctrl: assert property (!(i_psel && i_penable && i_pwrite) |=> $stable(ctrl))
        else $error("control bits changed without write");
    a_read_back: assert property (s_acc ##0 (!i_pwrite && i_paddr == 12'h000) |->
        o_prdata == {24'h0, ctrl}) else $error("read data wrong");
    a_level_low: assert property (o_range_select |=>
        o_reference_level == {4'h0, $past(o_tap_code), 8'd24}) else $error("low level");
    a_level_high: assert property (!o_range_select |=>
        o_reference_level == {8'd8 + {4'h0, $past(o_tap_code)}, 8'd32}) else $error("high level");
    a_pin_on: assert property (($past(o_pin_output_enable) && $past(i_port_a_direction, 3)) |->
        o_pin_connect) else $error("pin not connected");
    a_pin_off: assert property (!($past(o_pin_output_enable) && $past(i_port_a_direction, 3)) |->
        !o_pin_connect) else $error("pin connected");
    a_bad_addr: assert property (s_acc ##0 (i_paddr[11:3] != 9'h0) |-> o_pslverr)
        else $error("no error on unmapped address");
endmodule : cvr_ctrl_props
bind cvr_ctrl cvr_ctrl_props cvr_ctrl_props_inst (.*);
`default_nettype wire

// ==== tb/cvr_ctrl_test.sv ====
// Testbench for the reference control block.
// Assumes the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cvr_ctrl_test;
    import cvr_pkg::*;
    logic i_clk_sys, i_rst, i_psel, i_penable, i_pwrite, i_sleep, i_port_a_direction, err;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic [3:0] i_pstrb, o_tap_code;
    logic o_pready, o_pslverr, o_ladder_power_enable, o_source_select, o_range_select;
    logic o_pin_output_enable, o_pin_connect;
    cvr_level_t o_reference_level;
    int fail_count = 0;
    int n_compared = 0;
    wire [7:0] ctrl = {o_ladder_power_enable, o_pin_output_enable, o_range_select,
        o_source_select, o_tap_code};
    cvr_ctrl cvr_ctrl_inst (.*);
    // System clock
    initial begin
        i_clk_sys = 0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask : chk
    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    // One APB transfer, bounded wait for ready
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int k;
        @(posedge i_clk_sys);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge i_clk_sys);
            if (o_pready === 1'b1) break;
        end
        {rd, err} = {o_prdata, o_pslverr};
        {i_psel, i_penable} <= 2'b00;
        if (k == 16) begin
            fail_count++;
            results();
        end
    endtask : apb
    // Outputs, level and read back against a control byte
    task automatic outs(logic [7:0] v);
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk("ctrl", v, ctrl);
        chk("level", v[5] ? {4'h0, v[3:0], 8'd24} : {8'd8 + v[3:0], 8'd32}, o_reference_level);
        chk("pin", v[6] & i_port_a_direction, o_pin_connect);
        apb(0, 12'h000, 0);
        chk("read", v, rd);
    endtask : outs
    task automatic t_fields;
        logic [7:0] tab [7] = '{8'h80, 8'h40, 8'h2f, 8'h10, 8'h0f, 8'hff, 8'h20};
        foreach (tab[i]) begin
            apb(1, 12'h000, {24'hffffff, tab[i]});
            outs(tab[i]);
        end
        $display("t_fields end");
    endtask : t_fields
    task automatic t_sleep;
        apb(1, 12'h000, 32'hc5);
        i_sleep <= 1'b1;
        i_port_a_direction <= 1'b1;
        repeat (20) @(posedge i_clk_sys);
        i_sleep <= 1'b0;
        outs(8'hc5);
        i_port_a_direction <= 1'b0;
        $display("t_sleep end");
    endtask : t_sleep
    task automatic t_bad;
        apb(1, 12'h008, 32'h0);
        chk("err", 1, err);
        apb(1, 12'h004, 32'h0);
        chk("ro", 0, err);
        outs(8'hc5);
        $display("t_bad end");
    endtask : t_bad
    task automatic t_rst;
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        outs(8'h00);
        $display("t_rst end");
    endtask : t_rst
    // Main sequence
    initial begin
        {i_rst, i_psel, i_penable, i_pwrite, i_sleep, i_port_a_direction} = 6'b100000;
        {i_paddr, i_pwdata, i_pstrb} = {12'h0, 32'h0, 4'hf};
        repeat (16) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        outs(8'h00);
        t_fields();
        t_sleep();
        t_bad();
        t_rst();
        results();
    end
endmodule : cvr_ctrl_test
`default_nettype wire
